// ==== rtl/ppp_defs.svh ====
// What this block does
// - compatible mode drives written byte on data lines; reads return last written byte
// - extended mode direction bit gates output drivers; reads return data line levels
// - standard mode has data, status and control registers decoded on A0 and A1
// - enhanced mode generates address and data strobes; supports 1.7 and 1.9 handshakes
// - enhanced and extended hardware modes usable only after negotiation confirmed
// - watchdog ends a stalled enhanced-mode handshake so the bus never locks
// - enhanced mode adds five registers for wide accesses, decoded on A0 to A2
// - extended mode generates strobes automatically and expands run-length encoded input
// - extended mode has a two-way FIFO filled or drained by DMA or programmed I/O
// - extended mode matches base on A3-A9, offset from A0, A1, A10 (plus 400h) with A2 clear
// - extended control selects sub-mode; software sub-modes clear FIFO, stop DMA and RUN_LENGTH_DECOMPRESS
// - the 1.7 variant of extended sub-mode 4 is not implemented
// - configuration registers reached by index port then adjacent data port
// - control bit 0 low asserts strobe, bit 2 high asserts init, bit 3 low select
// - status bit 7 low when busy, bit 5 high paper out, bit 3 low on error
`ifndef PPP_DEFS_SVH
`define PPP_DEFS_SVH

// configuration port pair
`define PPP_CFG_INDEX_ADDR 11'h02E
`define PPP_CFG_DATA_ADDR 11'h02F
`define PPP_IDX_LDN 8'h07
`define PPP_LDN_PARALLEL 8'h04
`define PPP_IDX_ACTIVATE 8'h30
`define PPP_IDX_RANGE 8'h31
`define PPP_IDX_BASE_HI 8'h60
`define PPP_IDX_BASE_LO 8'h61
`define PPP_IDX_IRQ_SEL 8'h70
`define PPP_IDX_IRQ_TYPE 8'h71
`define PPP_IDX_DMA_SEL 8'h74
`define PPP_IDX_DMA_RPT 8'h75
`define PPP_IDX_OPTION 8'hF0

// configuration reset values
`define PPP_RST_ACTIVATE 8'h01
`define PPP_RST_RANGE 8'h00
`define PPP_RST_BASE_HI 8'h02
`define PPP_RST_BASE_LO 8'h78
`define PPP_RST_IRQ_SEL 8'h07
`define PPP_RST_IRQ_TYPE 8'h00
`define PPP_RST_DMA_SEL 8'h04
`define PPP_RST_OPTION 8'h00

// option bit fields
`define PPP_OPT_PERS_LSB 0
`define PPP_OPT_EPP19_BIT 2
`define PPP_OPT_NEGOK_BIT 3
`define PPP_OPT_EXT_BIT 4

// port register offsets
`define PPP_OFF_DATA 3'h0
`define PPP_OFF_STATUS 3'h1
`define PPP_OFF_CTL 3'h2
`define PPP_OFF_EPP_ADDR 3'h3
`define PPP_OFF_EPP_DATA0 3'h4
`define PPP_OFF_FIFO 3'h0
`define PPP_OFF_CFGB 3'h1
`define PPP_OFF_ECR 3'h2

// register values and bits
`define PPP_RST_CTL 8'h0B
`define PPP_CTL_DIR_BIT 5
`define PPP_CFGA_VALUE 8'h10
`define PPP_IRQ5 8'h05
`define PPP_ECR_DMA_BIT 3

// fifo shape
`define PPP_FIFO_DEPTH 16
`define PPP_FIFO_AW 4
`define PPP_FIFO_W 9

// timing
`define PPP_CLK_MHZ 25
`define PPP_STB_NS 500
`define PPP_STB_CYC 8'((`PPP_STB_NS * `PPP_CLK_MHZ + 999) / 1000)
`define PPP_WDOG_NS 10000
`define PPP_WDOG_CYC 8'((`PPP_WDOG_NS * `PPP_CLK_MHZ) / 1000)

`endif

// ==== rtl/ppp_pkg.sv ====
package ppp_pkg;
  // port personality from option bits
  typedef enum logic [1:0] {
    PERS_SPP = 2'h0,
    PERS_EPP = 2'h1,
    PERS_ECP = 2'h2
  } ppp_pers_t;

  // extended control sub-modes
  typedef enum logic [2:0] {
    ECR_STD = 3'h0,
    ECR_PS2 = 3'h1,
    ECR_PPF = 3'h2,
    ECR_ECP = 3'h3,
    ECR_EPP = 3'h4
  } ppp_ecr_mode_t;

  // handshake engine states
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_EPP_WAIT = 8'h02,
    ST_EPP_ACT = 8'h04,
    ST_FWD_ACT = 8'h08,
    ST_FWD_REL = 8'h10,
    ST_REV_ACT = 8'h20,
    ST_RLE = 8'h40
  } ppp_state_t;
endpackage : ppp_pkg

// ==== rtl/ppp_fifo_if.sv ====
`timescale 1ns/10ps
`include "ppp_defs.svh"
interface ppp_fifo_if;
  logic push;
  logic pop;
  logic flush;
  logic [`PPP_FIFO_W-1:0] wdata;
  logic [`PPP_FIFO_W-1:0] rdata;
  logic full;
  logic empty;
  modport owner(input push, pop, flush, wdata, output rdata, full, empty);
  modport user(output push, pop, flush, wdata, input rdata, full, empty);
endinterface : ppp_fifo_if

// ==== rtl/ppp_fifo.sv ====
`timescale 1ns/10ps
`include "ppp_defs.svh"
module ppp_fifo (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // fifo access
  ppp_fifo_if.owner f
);
  logic [`PPP_FIFO_W-1:0] mem [`PPP_FIFO_DEPTH];
  logic [`PPP_FIFO_AW:0] wp;
  logic [`PPP_FIFO_AW:0] rp;
  logic [`PPP_FIFO_AW:0] next_wp;
  logic [`PPP_FIFO_AW:0] next_rp;

  // flags from pointer wrap bit
  assign f.empty = (wp == rp);
  assign f.full = (wp[`PPP_FIFO_AW] != rp[`PPP_FIFO_AW]) &&
                  (wp[`PPP_FIFO_AW-1:0] == rp[`PPP_FIFO_AW-1:0]);
  assign f.rdata = mem[rp[`PPP_FIFO_AW-1:0]];

  // pointer update, flush wins
  always_comb begin
    next_wp = wp;
    next_rp = rp;
    if (f.flush) begin
      next_wp = '0;
      next_rp = '0;
    end else begin
      if (f.push && !f.full) begin
        next_wp = wp + 1'b1;
      end
      if (f.pop && !f.empty) begin
        next_rp = rp + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wp <= '0;
      rp <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk_i) begin
    if (f.push && !f.full && !f.flush) begin
      mem[wp[`PPP_FIFO_AW-1:0]] <= f.wdata;
    end
  end
endmodule : ppp_fifo

// ==== rtl/ppp_top.sv ====
`timescale 1ns/10ps
`include "ppp_defs.svh"
module ppp_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // host i/o bus
  input wire logic [10:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  output logic io_busy_o,
  // dma
  output logic dma_req_o,
  input wire logic dma_ack_i,
  // peripheral pins
  input wire logic [7:0] pd_i,
  output logic [7:0] pd_o,
  output logic pd_oe_o,
  output logic stb_n_o,
  output logic afd_n_o,
  output logic init_n_o,
  output logic sel_n_o,
  input wire logic ack_n_i,
  input wire logic busy_i,
  input wire logic pe_i,
  input wire logic slct_i,
  input wire logic fault_n_i
);
  ppp_pkg::ppp_state_t state, next_state;
  ppp_pkg::ppp_ecr_mode_t ecr_mode, next_ecr_mode;
  logic [7:0] cfg_idx, next_cfg_idx, ldn, next_ldn;
  logic [7:0] act, next_act, rng, next_rng, bhi, next_bhi, blo, next_blo;
  logic [7:0] isel, next_isel, ityp, next_ityp, dmac, next_dmac, opt, next_opt;
  logic [7:0] data_q, next_data_q, ctl, next_ctl, timer, next_timer;
  logic [7:0] next_rdata, next_pd;
  logic [6:0] rle_cnt, next_rle_cnt;
  logic ecr_dma, next_ecr_dma, tmo, next_tmo, cmd_q, next_cmd_q;
  logic epp_rd, next_epp_rd, epp_adr, next_epp_adr, rle_pend, next_rle_pend;
  logic next_busy, next_dreq, next_oe, next_stb_n, next_afd_n, next_init_n, next_sel_n;
  logic [9:0] base;
  logic hit, hi, epp_on, ecp_on, hwm, rev_mode, dir_eff, dma_cyc;
  logic [2:0] off;
  logic [7:0] cfg_rd, stat_rd;
  ppp_fifo_if fif ();

  ppp_fifo u_fifo (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .f(fif)
  );

  // sub-modes that run the hardware handshake
  function automatic logic ppp_is_hw(input ppp_pkg::ppp_ecr_mode_t m);
    return (m == ppp_pkg::ECR_PPF) || (m == ppp_pkg::ECR_ECP);
  endfunction : ppp_is_hw

  // personality and decode
  assign base = {bhi[1:0], blo};
  assign epp_on = (opt[1:0] == ppp_pkg::PERS_EPP) && opt[`PPP_OPT_NEGOK_BIT];
  assign ecp_on = (opt[1:0] == ppp_pkg::PERS_ECP) && opt[`PPP_OPT_NEGOK_BIT];
  assign hwm = ecp_on && ppp_is_hw(ecr_mode);
  assign rev_mode = hwm && (ecr_mode == ppp_pkg::ECR_ECP) && ctl[`PPP_CTL_DIR_BIT];
  assign hi = io_addr_i[10];
  assign off = io_addr_i[2:0];
  // low regs on A0-A2, high regs on A10 with A2 clear
  assign hit = act[0] && (io_addr_i[9:3] == base[9:3]) &&
               (hi ? ((opt[1:0] == ppp_pkg::PERS_ECP) && !io_addr_i[2])
                   : (epp_on || (off <= `PPP_OFF_CTL)));
  assign dma_cyc = dma_ack_i && (io_wr_i || io_rd_i);
  assign stat_rd = {~busy_i, ack_n_i, pe_i, slct_i, fault_n_i, 2'b00, tmo};
  // direction bit honoured in odd extended sub-modes, in enhanced mode and with the extended option bit
  always_comb begin
    dir_eff = 1'b0;
    if (opt[1:0] == ppp_pkg::PERS_ECP) begin
      dir_eff = ecr_mode[0] && ctl[`PPP_CTL_DIR_BIT];
    end else if (opt[1:0] == ppp_pkg::PERS_EPP) begin
      dir_eff = ctl[`PPP_CTL_DIR_BIT];
    end else begin
      dir_eff = opt[`PPP_OPT_EXT_BIT] && ctl[`PPP_CTL_DIR_BIT];
    end
  end

  // configuration register read mux
  always_comb begin
    cfg_rd = 8'h00;
    if (cfg_idx == `PPP_IDX_LDN) begin
      cfg_rd = ldn;
    end else if (ldn == `PPP_LDN_PARALLEL) begin
      case (cfg_idx)
        `PPP_IDX_ACTIVATE: cfg_rd = act;
        `PPP_IDX_RANGE: cfg_rd = rng;
        `PPP_IDX_BASE_HI: cfg_rd = bhi;
        `PPP_IDX_BASE_LO: cfg_rd = blo;
        `PPP_IDX_IRQ_SEL: cfg_rd = isel;
        `PPP_IDX_IRQ_TYPE: cfg_rd = ityp;
        `PPP_IDX_DMA_SEL: cfg_rd = dmac;
        `PPP_IDX_DMA_RPT: cfg_rd = dmac;
        `PPP_IDX_OPTION: cfg_rd = opt;
        default: cfg_rd = 8'h00;
      endcase
    end
  end

  // bus, fifo and handshake next state
  always_comb begin
    next_state = state;
    next_cfg_idx = cfg_idx;
    next_ldn = ldn;
    next_act = act;
    next_rng = rng;
    next_bhi = bhi;
    next_blo = blo;
    next_isel = isel;
    next_ityp = ityp;
    next_dmac = dmac;
    next_opt = opt;
    next_data_q = data_q;
    next_ctl = ctl;
    next_ecr_mode = ecr_mode;
    next_ecr_dma = ecr_dma;
    next_tmo = tmo;
    next_cmd_q = cmd_q;
    next_epp_rd = epp_rd;
    next_epp_adr = epp_adr;
    next_rle_pend = rle_pend;
    next_rle_cnt = rle_cnt;
    next_timer = timer;
    next_rdata = io_rdata_o;
    next_busy = io_busy_o;
    fif.push = 1'b0;
    fif.pop = 1'b0;
    fif.wdata = '0;
    fif.flush = !hwm;
    if (dma_cyc && hwm && ecr_dma) begin
      // dma moves fifo bytes without address decode
      if (io_wr_i && !rev_mode) begin
        fif.push = 1'b1;
        fif.wdata = {1'b0, io_wdata_i};
      end else if (io_rd_i && rev_mode) begin
        fif.pop = 1'b1;
        next_rdata = fif.rdata[7:0];
      end
    end else if (io_wr_i && !dma_ack_i && !io_busy_o) begin
      if (io_addr_i == `PPP_CFG_INDEX_ADDR) begin
        next_cfg_idx = io_wdata_i;
      end else if (io_addr_i == `PPP_CFG_DATA_ADDR) begin
        if (cfg_idx == `PPP_IDX_LDN) begin
          next_ldn = io_wdata_i;
        end else if (ldn == `PPP_LDN_PARALLEL) begin
          case (cfg_idx)
            `PPP_IDX_ACTIVATE: next_act = io_wdata_i;
            `PPP_IDX_RANGE: next_rng = io_wdata_i;
            `PPP_IDX_BASE_HI: next_bhi = io_wdata_i;
            `PPP_IDX_BASE_LO: next_blo = io_wdata_i;
            `PPP_IDX_IRQ_SEL: next_isel = io_wdata_i;
            `PPP_IDX_IRQ_TYPE: next_ityp = io_wdata_i;
            `PPP_IDX_DMA_SEL: next_dmac = io_wdata_i;
            `PPP_IDX_OPTION: next_opt = io_wdata_i;
            default: next_ldn = ldn;
          endcase
        end
      end else if (hit && hi) begin
        if (off == `PPP_OFF_FIFO && hwm && !rev_mode) begin
          fif.push = 1'b1;
          fif.wdata = {1'b0, io_wdata_i};
        end else if (off == `PPP_OFF_ECR) begin
          next_ecr_mode = ppp_pkg::ppp_ecr_mode_t'(io_wdata_i[7:5]);
          next_ecr_dma = io_wdata_i[`PPP_ECR_DMA_BIT];
        end
      end else if (hit) begin
        if (off == `PPP_OFF_DATA) begin
          if (hwm && !rev_mode) begin
            fif.push = 1'b1; // tagged command byte
            fif.wdata = {1'b1, io_wdata_i};
          end else begin
            next_data_q = io_wdata_i;
          end
        end else if (off == `PPP_OFF_CTL) begin
          next_ctl = io_wdata_i;
        end else if (off >= `PPP_OFF_EPP_ADDR && state == ppp_pkg::ST_IDLE) begin
          next_data_q = io_wdata_i;
          next_epp_adr = (off == `PPP_OFF_EPP_ADDR);
          next_epp_rd = 1'b0;
          next_busy = 1'b1;
          next_timer = 8'h00;
          next_state = opt[`PPP_OPT_EPP19_BIT] ? ppp_pkg::ST_EPP_WAIT
                                               : ppp_pkg::ST_EPP_ACT;
        end
      end
    end else if (io_rd_i && !dma_ack_i && !io_busy_o) begin
      next_rdata = 8'h00;
      if (io_addr_i == `PPP_CFG_INDEX_ADDR) begin
        next_rdata = cfg_idx;
      end else if (io_addr_i == `PPP_CFG_DATA_ADDR) begin
        next_rdata = cfg_rd;
      end else if (hit && hi) begin
        case (off)
          `PPP_OFF_FIFO: begin
            if (rev_mode) begin
              fif.pop = 1'b1;
              next_rdata = fif.rdata[7:0];
            end else begin
              next_rdata = `PPP_CFGA_VALUE;
            end
          end
          `PPP_OFF_CFGB: next_rdata = {2'b00, (isel == `PPP_IRQ5) ? 2'b11 : 2'b00, 4'h8};
          `PPP_OFF_ECR: next_rdata = {ecr_mode, 1'b0, ecr_dma, 1'b0, fif.full, fif.empty};
          default: next_rdata = 8'h00;
        endcase
      end else if (hit) begin
        if (off == `PPP_OFF_DATA) begin
          next_rdata = (dir_eff || opt[`PPP_OPT_EXT_BIT] || opt[1:0] != ppp_pkg::PERS_SPP)
                       ? pd_i : data_q;
        end else if (off == `PPP_OFF_STATUS) begin
          next_rdata = stat_rd;
          next_tmo = 1'b0;
        end else if (off == `PPP_OFF_CTL) begin
          next_rdata = {2'b00, ctl[5:0]};
        end else if (state == ppp_pkg::ST_IDLE) begin
          next_epp_adr = (off == `PPP_OFF_EPP_ADDR);
          next_epp_rd = 1'b1;
          next_busy = 1'b1;
          next_timer = 8'h00;
          next_state = opt[`PPP_OPT_EPP19_BIT] ? ppp_pkg::ST_EPP_WAIT
                                               : ppp_pkg::ST_EPP_ACT;
        end
      end
    end
    // handshake engine
    case (state)
      ppp_pkg::ST_IDLE: begin
        if (hwm && !rev_mode && !fif.empty && !fif.pop) begin
          fif.pop = 1'b1;
          next_data_q = fif.rdata[7:0];
          next_cmd_q = fif.rdata[8];
          next_timer = 8'h00;
          next_state = ppp_pkg::ST_FWD_ACT;
        end else if (rev_mode && !ack_n_i && !fif.full && !fif.push) begin
          next_state = ppp_pkg::ST_REV_ACT;
          if (!busy_i && !pd_i[7]) begin
            next_rle_pend = 1'b1;
            next_rle_cnt = pd_i[6:0];
          end else if (rle_pend && busy_i) begin
            next_data_q = pd_i;
            next_rle_pend = 1'b0;
            next_state = ppp_pkg::ST_RLE;
          end else begin
            fif.push = 1'b1;
            fif.wdata = {~busy_i, pd_i};
          end
        end
      end
      ppp_pkg::ST_EPP_WAIT: begin
        next_timer = timer + 8'h01;
        if (!busy_i) begin
          next_state = ppp_pkg::ST_EPP_ACT;
        end
      end
      ppp_pkg::ST_EPP_ACT: begin
        next_timer = timer + 8'h01;
        if (busy_i) begin
          if (epp_rd) begin
            next_rdata = pd_i;
          end
          next_busy = 1'b0;
          next_state = ppp_pkg::ST_IDLE;
        end
      end
      ppp_pkg::ST_FWD_ACT: begin
        if (timer < `PPP_STB_CYC) begin
          next_timer = timer + 8'h01;
        end else if (busy_i) begin
          next_state = ppp_pkg::ST_FWD_REL;
        end
      end
      ppp_pkg::ST_FWD_REL: begin
        if (!busy_i) begin
          next_state = ppp_pkg::ST_IDLE;
        end
      end
      ppp_pkg::ST_REV_ACT: begin
        if (ack_n_i) begin
          next_state = ppp_pkg::ST_IDLE;
        end
      end
      ppp_pkg::ST_RLE: begin
        if (!fif.full && !fif.push) begin
          fif.push = 1'b1;
          fif.wdata = {1'b0, data_q};
          next_rle_cnt = rle_cnt - 7'h01;
          if (rle_cnt == 7'h00) begin
            next_state = ppp_pkg::ST_REV_ACT;
          end
        end
      end
      default: next_state = ppp_pkg::ST_IDLE;
    endcase
    // stalled enhanced handshake aborted, flag set over clear
    if ((state == ppp_pkg::ST_EPP_WAIT || state == ppp_pkg::ST_EPP_ACT) &&
        !busy_i == (state == ppp_pkg::ST_EPP_ACT) && timer >= `PPP_WDOG_CYC - 8'h01) begin
      next_tmo = 1'b1;
      next_busy = 1'b0;
      next_rdata = 8'hFF;
      next_state = ppp_pkg::ST_IDLE;
    end
    // leaving hardware sub-modes drops any transfer
    if (!hwm && (state == ppp_pkg::ST_FWD_ACT || state == ppp_pkg::ST_FWD_REL ||
                 state == ppp_pkg::ST_REV_ACT || state == ppp_pkg::ST_RLE)) begin
      next_state = ppp_pkg::ST_IDLE;
      next_rle_pend = 1'b0;
    end
    if (!hwm) begin
      next_rle_pend = 1'b0;
    end
    next_dreq = hwm && ecr_dma && (rev_mode ? !fif.empty : !fif.full);
  end

  // pin levels for the coming cycle
  always_comb begin
    next_pd = next_data_q;
    next_oe = !dir_eff;
    next_stb_n = next_ctl[0];
    next_afd_n = next_ctl[1];
    next_init_n = !next_ctl[2];
    next_sel_n = next_ctl[3];
    if (epp_on) begin
      next_stb_n = 1'b1;
      next_afd_n = 1'b1;
      next_sel_n = 1'b1;
    end
    if (rev_mode) begin
      next_oe = 1'b0;
      next_afd_n = 1'b0;
    end
    case (next_state)
      ppp_pkg::ST_EPP_WAIT: begin
        next_stb_n = next_epp_rd;
        next_oe = !next_epp_rd;
      end
      ppp_pkg::ST_EPP_ACT: begin
        next_stb_n = next_epp_rd;
        next_oe = !next_epp_rd;
        next_sel_n = !next_epp_adr;
        next_afd_n = next_epp_adr;
      end
      ppp_pkg::ST_FWD_ACT: begin
        next_stb_n = 1'b0;
        next_afd_n = !next_cmd_q;
      end
      ppp_pkg::ST_FWD_REL: next_afd_n = !next_cmd_q;
      ppp_pkg::ST_REV_ACT: next_afd_n = 1'b1;
      ppp_pkg::ST_RLE: next_afd_n = 1'b0;
      default: next_oe = next_oe;
    endcase
  end

  // register all state and outputs
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= ppp_pkg::ST_IDLE;
      cfg_idx <= 8'h00;
      ldn <= 8'h00;
      act <= `PPP_RST_ACTIVATE;
      rng <= `PPP_RST_RANGE;
      bhi <= `PPP_RST_BASE_HI;
      blo <= `PPP_RST_BASE_LO;
      isel <= `PPP_RST_IRQ_SEL;
      ityp <= `PPP_RST_IRQ_TYPE;
      dmac <= `PPP_RST_DMA_SEL;
      opt <= `PPP_RST_OPTION;
      data_q <= 8'h00;
      ctl <= `PPP_RST_CTL;
      ecr_mode <= ppp_pkg::ECR_STD;
      ecr_dma <= 1'b0;
      tmo <= 1'b0;
      cmd_q <= 1'b0;
      epp_rd <= 1'b0;
      epp_adr <= 1'b0;
      rle_pend <= 1'b0;
      rle_cnt <= 7'h00;
      timer <= 8'h00;
      io_rdata_o <= 8'h00;
      io_busy_o <= 1'b0;
      dma_req_o <= 1'b0;
      pd_o <= 8'h00;
      pd_oe_o <= 1'b1;
      stb_n_o <= 1'b1;
      afd_n_o <= 1'b1;
      init_n_o <= 1'b1;
      sel_n_o <= 1'b1;
    end else begin
      state <= next_state;
      cfg_idx <= next_cfg_idx;
      ldn <= next_ldn;
      act <= next_act;
      rng <= next_rng;
      bhi <= next_bhi;
      blo <= next_blo;
      isel <= next_isel;
      ityp <= next_ityp;
      dmac <= next_dmac;
      opt <= next_opt;
      data_q <= next_data_q;
      ctl <= next_ctl;
      ecr_mode <= next_ecr_mode;
      ecr_dma <= next_ecr_dma;
      tmo <= next_tmo;
      cmd_q <= next_cmd_q;
      epp_rd <= next_epp_rd;
      epp_adr <= next_epp_adr;
      rle_pend <= next_rle_pend;
      rle_cnt <= next_rle_cnt;
      timer <= next_timer;
      io_rdata_o <= next_rdata;
      io_busy_o <= next_busy;
      dma_req_o <= next_dreq;
      pd_o <= next_pd;
      pd_oe_o <= next_oe;
      stb_n_o <= next_stb_n;
      afd_n_o <= next_afd_n;
      init_n_o <= next_init_n;
      sel_n_o <= next_sel_n;
    end
  end
endmodule : ppp_top

// ==== dv/ppp_periph.sv ====
`timescale 1ns/10ps
module ppp_periph (
  // clock and test controls
  input wire logic clk_i,
  input wire logic stall_i,
  input wire logic epp_i,
  // host side pins
  input wire logic [7:0] hd_i,
  input wire logic oe_i,
  input wire logic stb_n_i,
  input wire logic afd_n_i,
  input wire logic sel_n_i,
  // peripheral answers
  output logic [7:0] ld_o,
  output logic busy_o,
  output logic ack_n_o
);
  logic [2:0] dly = 3'h0;
  logic [5:0] ack = 6'h0;
  logic stb_q = 1'b1;
  // host drive wins on the wire, else our reply byte
  assign ld_o = oe_i ? hd_i : 8'hA5;
  // busy trails the strobe by three cycles, stall pins it high
  assign busy_o = stall_i | dly[2];
  assign ack_n_o = ~|ack;
  // strobe history and acknowledge stretch
  always @(posedge clk_i) begin
    dly <= {dly[1:0], epp_i ? ~(afd_n_i & sel_n_i) : ~stb_n_i};
    stb_q <= stb_n_i;
    ack <= {ack[4:0], stb_n_i & ~stb_q};
  end
endmodule : ppp_periph

// ==== dv/ppp_properties.sv ====
`timescale 1ns/10ps
module ppp_props (
  input wire logic clk_i, nrst_i, io_wr_i, io_rd_i, io_busy_o,
  input wire logic [10:0] io_addr_i,
  input wire logic [7:0] io_wdata_i, io_rdata_o, pd_o,
  input wire logic stb_n_o, afd_n_o, init_n_o, sel_n_o,
  input wire logic busy_i, ack_n_i, pe_i, slct_i, fault_n_i
);
  localparam logic [10:0] B = 11'h278;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic [9:0] bcnt;
  logic [9:0] next_bcnt;
  logic [4:0] st;
  // status pins as they should read back
  assign st = {~busy_i, ack_n_i, pe_i, slct_i, fault_n_i};
  // length of the current busy stretch
  always_comb next_bcnt = io_busy_o ? bcnt + 10'h1 : 10'h0;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) bcnt <= 10'h0;
    else bcnt <= next_bcnt;
  end
  a_data_pins: assert property (!io_busy_o && io_wr_i && io_addr_i == B
    |=> pd_o == $past(io_wdata_i)) else $error("data pins miss byte");
  a_ctl_pins: assert property (!io_busy_o && io_wr_i && io_addr_i == B + 11'h2 |=>
    {sel_n_o, init_n_o, afd_n_o, stb_n_o} == {$past(io_wdata_i[3]),
    !$past(io_wdata_i[2]), $past(io_wdata_i[1:0])}) else $error("control pins wrong");
  a_status_map: assert property (!io_busy_o && io_rd_i && io_addr_i == B + 11'h1
    && $past(st) == st && $past(st, 2) == st && $past(st, 3) == st
    |=> io_rdata_o[7:3] == $past(st)) else $error("status bits wrong");
  a_unmapped_zero: assert property (!io_busy_o && io_rd_i && io_addr_i == 11'h100
    |=> io_rdata_o == 8'h00) else $error("unmapped read not zero");
  a_rdata_hold: assert property (!$past(io_rd_i) && !$past(io_busy_o)
    |-> $stable(io_rdata_o)) else $error("read data moved");
  a_busy_cause: assert property ($rose(io_busy_o) |-> $past(io_wr_i || io_rd_i))
    else $error("busy without access");
  a_busy_bound: assert property (bcnt < 10'h208) else $error("busy never ended");
  a_epp_write: assert property ($rose(io_busy_o) && $past(io_wr_i) |-> !stb_n_o)
    else $error("write line not low");
  c_epp: cover property ($fell(io_busy_o));
  c_strobe: cover property ($fell(stb_n_o));
  c_ack: cover property ($fell(ack_n_i));
endmodule : ppp_props
bind ppp_top ppp_props chk_u (.clk_i(clk_i), .nrst_i(nrst_i), .io_wr_i(io_wr_i),
  .io_rd_i(io_rd_i), .io_busy_o(io_busy_o), .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i),
  .io_rdata_o(io_rdata_o), .pd_o(pd_o), .stb_n_o(stb_n_o), .afd_n_o(afd_n_o),
  .init_n_o(init_n_o), .sel_n_o(sel_n_o), .busy_i(busy_i), .ack_n_i(ack_n_i),
  .pe_i(pe_i), .slct_i(slct_i), .fault_n_i(fault_n_i));

// ==== dv/parallel_printer_port_tb.sv ====
`timescale 1ns/10ps
module parallel_printer_port_tb;
  localparam logic [10:0] B = 11'h278;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [10:0] io_addr_i = 11'h0;
  logic io_wr_i = 1'b0;
  logic io_rd_i = 1'b0;
  logic [7:0] io_wdata_i = 8'h00;
  logic pe_i = 1'b0;
  logic slct_i = 1'b1;
  logic fault_n_i = 1'b1;
  logic stall = 1'b0;
  logic dma_ack_i = 1'b0;
  logic epp = 1'b0;
  logic [7:0] io_rdata_o, pd_i, pd_o, r;
  logic io_busy_o, dma_req_o, pd_oe_o, stb_n_o, afd_n_o, init_n_o, sel_n_o, ack_n_i, busy_i;
  int fails = 0;
  int tests_run = 0;
  int n;
  logic [7:0] ix [8] = '{8'h30, 8'h31, 8'h60, 8'h61, 8'h70, 8'h71, 8'h74, 8'h75};
  logic [7:0] rv [8] = '{8'h01, 8'h00, 8'h02, 8'h78, 8'h07, 8'h00, 8'h04, 8'h04};
  logic [7:0] cv [3] = '{8'h0A, 8'h04, 8'h02};
  // 25 MHz clock
  always #20 clk_i = ~clk_i;
  ppp_top dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
    .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .io_busy_o(io_busy_o),
    .dma_req_o(dma_req_o), .dma_ack_i(dma_ack_i), .pd_i(pd_i), .pd_o(pd_o), .pd_oe_o(pd_oe_o),
    .stb_n_o(stb_n_o), .afd_n_o(afd_n_o), .init_n_o(init_n_o), .sel_n_o(sel_n_o),
    .ack_n_i(ack_n_i), .busy_i(busy_i), .pe_i(pe_i), .slct_i(slct_i), .fault_n_i(fault_n_i));
  ppp_periph per_u (.clk_i(clk_i), .stall_i(stall), .epp_i(epp), .hd_i(pd_o), .oe_i(pd_oe_o),
    .stb_n_i(stb_n_o), .afd_n_i(afd_n_o), .sel_n_i(sel_n_o), .ld_o(pd_i), .busy_o(busy_i),
    .ack_n_o(ack_n_i));
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge clk_i);
    io_addr_i <= a;
    io_wdata_i <= d;
    io_wr_i <= 1'b1;
    @(posedge clk_i);
    io_wr_i <= 1'b0;
  endtask : wr
  task automatic wt;
    n = 0;
    #1;
    while (io_busy_o === 1'b1 && n < 600) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    // a cycle that never ends counts against the run
    if (n >= 600) begin
      fails++;
    end
  endtask : wt
  task automatic rd(input logic [10:0] a);
    @(posedge clk_i);
    io_addr_i <= a;
    io_rd_i <= 1'b1;
    @(posedge clk_i);
    io_rd_i <= 1'b0;
    wt();
    r = io_rdata_o;
  endtask : rd
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic cfg(input logic [7:0] i, input logic [7:0] d);
    wr(11'h02E, i);
    wr(11'h02F, d);
  endtask : cfg
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    end_of_test();
  end
  // test sequence
  initial begin
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    #1 chk({3'h0, stb_n_o, afd_n_o, init_n_o, sel_n_o, pd_oe_o}, 8'h1F);
    cfg(8'h07, 8'h04);
    for (int k = 0; k < 8; k++) begin
      wr(11'h02E, ix[k]);
      rd(11'h02F);
      chk(r, rv[k]);
    end
    cfg(8'h75, 8'hFF);
    rd(11'h02F);
    chk(r, 8'h04);
    cfg(8'h30, 8'h01);
    $display("test config done");
    rd(B + 11'h1);
    chk(r, 8'hD8);
    pe_i <= 1'b1;
    fault_n_i <= 1'b0;
    rd(B + 11'h1);
    rd(B + 11'h1);
    chk(r, 8'hF0);
    pe_i <= 1'b0;
    fault_n_i <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      wr(B, cv[k] ^ 8'h5F);
      #1 chk(pd_o, cv[k] ^ 8'h5F);
      rd(B);
      chk(r, cv[k] ^ 8'h5F);
      wr(B + 11'h2, cv[k]);
      #1 chk({sel_n_o, init_n_o, afd_n_o, stb_n_o}, {cv[k][3], ~cv[k][2], cv[k][1:0]});
      repeat (13) @(posedge clk_i);
      wr(B + 11'h2, 8'h0B);
      r = 8'hFF;
      for (int j = 0; j < 40 && r[6]; j++) rd(B + 11'h1);
      chk({7'h0, r[6]}, 8'h00);
    end
    rd(B + 11'h3);
    chk(r, 8'h00);
    rd(11'h100);
    chk(r, 8'h00);
    cfg(8'hF0, 8'h10);
    wr(B + 11'h2, 8'h2B);
    // drivers follow the direction bit one cycle after the write
    @(posedge clk_i);
    #1 chk({7'h0, pd_oe_o}, 8'h00);
    rd(B);
    chk(r, 8'hA5);
    rd(B + 11'h2);
    chk(r, 8'h2B);
    wr(B + 11'h2, 8'h0B);
    $display("test standard done");
    epp <= 1'b1;
    cfg(8'hF0, 8'h05);
    rd(B + 11'h4);
    chk(r, 8'h00);
    cfg(8'hF0, 8'h0D);
    wr(B + 11'h4, 8'h3C);
    wt();
    chk({7'h0, n > 2}, 8'h01);
    chk(pd_o, 8'h3C);
    rd(B + 11'h5);
    chk(r, 8'hA5);
    cfg(8'hF0, 8'h09);
    wr(B + 11'h3, 8'h11);
    wt();
    chk(pd_o, 8'h11);
    cfg(8'hF0, 8'h0D);
    stall <= 1'b1;
    wr(B + 11'h4, 8'h77);
    wt();
    chk({7'h0, n >= 245 && n <= 256}, 8'h01);
    rd(B + 11'h1);
    chk(r & 8'h81, 8'h01);
    rd(B + 11'h1);
    chk(r & 8'h01, 8'h00);
    $display("test enhanced done");
    epp <= 1'b0;
    cfg(8'hF0, 8'h0A);
    rd(B + 11'h400);
    chk(r, 8'h10);
    rd(B + 11'h401);
    chk(r, 8'h08);
    wr(B + 11'h402, 8'h40);
    wr(B + 11'h400, 8'hC3);
    wr(B + 11'h400, 8'h3C);
    rd(B + 11'h402);
    chk(r, 8'h40);
    wr(B + 11'h402, 8'h28);
    rd(B + 11'h402);
    chk(r, 8'h29);
    chk({7'h0, dma_req_o}, 8'h00);
    wr(B + 11'h402, 8'h88);
    wr(B + 11'h400, 8'h11);
    rd(B + 11'h402);
    chk(r, 8'h89);
    stall <= 1'b0;
    wr(B + 11'h402, 8'h48);
    wr(B + 11'h400, 8'h3C);
    dma_ack_i <= 1'b1;
    wr(11'h000, 8'h5A);
    dma_ack_i <= 1'b0;
    repeat (120) @(posedge clk_i);
    rd(B + 11'h402);
    chk(r, 8'h49);
    chk(pd_o, 8'h5A);
    chk({7'h0, dma_req_o}, 8'h01);
    // reverse fifo mode: one strobe pulse makes the model acknowledge a byte
    wr(B + 11'h402, 8'h68);
    wr(B + 11'h2, 8'h2A);
    wr(B + 11'h2, 8'h29);
    repeat (8) @(posedge clk_i);
    rd(B + 11'h400);
    chk(r, 8'hA5);
    $display("test extended done");
    end_of_test();
  end
endmodule : parallel_printer_port_tb
